// file: pkg/svdc_pkg.sv
// shared constants and types for the smbus vid divider control block
package svdc_pkg;

    // ------------------------------------------------------------
    // divider codes and stored state
    // ------------------------------------------------------------
    localparam int CODE_W = 5;
    localparam logic [4:0] CODE_RESET = 5'h1f;
    localparam logic BUS_ON_RESET = 1'b0;
    localparam int CONV_N = 3;
    localparam logic [2:0] CONV_ALL_LOW = 3'h7;
    localparam logic [2:0] CONV_ALL_FREE = 3'h0;

    // ------------------------------------------------------------
    // serial command set; address value is arbitrary
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
    localparam logic [7:0] CMD_SETTING0 = 8'h00;
    localparam logic [7:0] CMD_SETTING1 = 8'h01;
    localparam logic [7:0] CMD_ON_STATE = 8'h02;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // read-back word layout carried into the link domain
    // ------------------------------------------------------------
    localparam int RB_W = 11;
    localparam int RB_S0_LSB = 0;
    localparam int RB_S1_LSB = 5;
    localparam int RB_ON_BIT = 10;

    // ------------------------------------------------------------
    // power-good low pulse timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PGL_NOM_US = 50;
    localparam int PGL_MAX_US = 70;
    localparam int PGL_CYCLES = (PGL_NOM_US * 1000) / CLK_PERIOD_NS;
    localparam int PGL_MAX_CYCLES = (PGL_MAX_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PH_ADDR, PH_CMD, PH_WLO, PH_WHI, PH_RLO, PH_RHI, PH_IDLE
    } svdc_phase_e;

endpackage

// file: src/svdc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module svdc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("svdc_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_q;

    // meta_q feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // svdc_sync

`default_nettype wire

// file: src/svdc_timer.sv
// retriggerable one-shot timer for the power-good low pulse
`timescale 1ns/1ps
`default_nettype none

module svdc_timer #(
    parameter int CYCLES = 2000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // trigger and state
    input wire logic start,
    output logic busy
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);

    if (CYCLES < 1)
    begin : g_bad_cycles
        $error("svdc_timer: CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // a new trigger restarts the full length
    assign cnt_d = start ? LOAD : (busy ? cnt_q - ONE : cnt_q);
    assign busy = (cnt_q != '0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    load_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        start |=> cnt_q == LOAD) else $error("timer did not load full length");

endmodule // svdc_timer

`default_nettype wire

// file: src/svdc_top.sv
// smbus vid divider control: serial slave, stored codes, converter and power-good control
//
// Notes on behaviour
// - two stored divider codes; the select input picks which one drives the output.
// - serial slave follows two-wire smbus conventions; both codes are writable.
// - write word loads either code or the on/off state.
// - read word returns stored codes and the on/off state.
// - three open-drain converter run outputs enable or shut down converters.
// - one global control input switches all three run outputs together.
// - power-good is held low 50 us after code change or converter turn-on.
// - toggling select to a different stored code starts the power-good pulse.
// - global control low pulls all three run outputs low.
// - global control low also pulls power-good low.
// - select low uses the first code, select high the second.
// - both stored codes start at all ones after reset.
// - serial data sampled on clock rise, read data shifted out on clock fall.
// - run outputs released only with bus on state and global control both high.
`timescale 1ns/1ps
`default_nettype none

module svdc_top
    import svdc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
    parameter int PGL_LEN = PGL_CYCLES
) (
    // system clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // serial link; SCL also clocks the link logic
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // control inputs
    input wire logic SELECT,
    input wire logic GLOBAL_SUPPLY_CONTROL,
    // selected divider code
    output logic [CODE_W-1:0] VOLTAGE_ID_CODE,
    // open-drain converter run outputs
    output logic [CONV_N-1:0] CONV_RUN_O,
    output logic [CONV_N-1:0] CONV_RUN_OE,
    // open-drain power-good output
    output logic POWER_OK_OUT_O,
    output logic POWER_OK_OUT_OE
);

    if (PGL_LEN < 1 || PGL_LEN > PGL_MAX_CYCLES)
    begin : g_bad_pgl
        $error("svdc_top: PGL_LEN outside 1 .. maximum pulse length");
    end

    // ------------------------------------------------------------
    // decoding shared by receive and acknowledge paths
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] b);
        return b[7:1] == DEV_ADDR;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and bus condition detection
    // ------------------------------------------------------------
    logic [3:0] pin_s;
    logic sda_p_q;
    logic scl_p_q;
    logic frame_clr_q;
    logic frame_clr_d;

    svdc_sync #(.WIDTH(4)) u_pin_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .async_in({SCL, SDA_I, SELECT, GLOBAL_SUPPLY_CONTROL}),
        .sync_out(pin_s)
    );

    wire scl_s = pin_s[3];
    wire sda_s = pin_s[2];
    wire sel_s = pin_s[1];
    wire global_supply_control_s = pin_s[0];
    // scl must read high on two samples, so the synchroniser's release after reset
    // never shows up as a false stop
    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // link logic is held in reset from start or stop until scl is low again,
    // so its release never lands near an scl edge
    assign frame_clr_d = (start_det | stop_det) ? 1'b1 : (scl_s & frame_clr_q);
    wire link_rst_n = RST_N & ~frame_clr_q;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sda_p_q <= 1'b1;
            scl_p_q <= 1'b0;
            frame_clr_q <= 1'b1;
        end
        else
        begin
            sda_p_q <= sda_s;
            scl_p_q <= scl_s;
            frame_clr_q <= frame_clr_d;
        end
    end

    // ------------------------------------------------------------
    // link domain: byte receiver on the rising scl edge
    // ------------------------------------------------------------
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] sr_q;
    logic [7:0] sr_d;
    svdc_phase_e ph_q;
    svdc_phase_e ph_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic [7:0] lo_q;
    logic [7:0] lo_d;
    logic wr_tog_q;
    logic wr_tog_d;
    logic sda_oe_q;
    logic [RB_W-1:0] rb_s;

    wire ack_slot = (bit_q == ACK_SLOT);

    always_comb
    begin
        bit_d = ack_slot ? '0 : bit_q + 4'h1;
        sr_d = ack_slot ? sr_q : {sr_q[6:0], SDA_I};
        ph_d = ph_q;
        cmd_d = cmd_q;
        lo_d = lo_q;
        wr_tog_d = wr_tog_q;
        if (ack_slot)
        begin
            case (ph_q)
                PH_ADDR: ph_d = !addr_hit(sr_q) ? PH_IDLE : (sr_q[0] ? PH_RLO : PH_CMD);
                PH_CMD:
                begin
                    cmd_d = sr_q;
                    ph_d = PH_WLO;
                end
                PH_WLO:
                begin
                    lo_d = sr_q;
                    ph_d = PH_WHI;
                end
                PH_WHI:
                begin
                    wr_tog_d = ~wr_tog_q;
                    ph_d = PH_IDLE;
                end
                PH_RLO: ph_d = SDA_I ? PH_IDLE : PH_RHI;
                default: ph_d = PH_IDLE;
            endcase
        end
    end

    // frame position restarts on every start condition
    always_ff @(posedge SCL or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bit_q <= '0;
            sr_q <= BYTE_ZERO;
            ph_q <= PH_ADDR;
        end
        else
        begin
            bit_q <= bit_d;
            sr_q <= sr_d;
            ph_q <= ph_d;
        end
    end

    // command survives a repeated start so a read can follow it
    always_ff @(posedge SCL or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cmd_q <= BYTE_ZERO;
            lo_q <= BYTE_ZERO;
            wr_tog_q <= 1'b0;
        end
        else
        begin
            cmd_q <= cmd_d;
            lo_q <= lo_d;
            wr_tog_q <= wr_tog_d;
        end
    end

    // ------------------------------------------------------------
    // link domain: acknowledge and read data on the falling scl edge
    // ------------------------------------------------------------
    logic [CODE_W-1:0] setting0_q;
    logic [CODE_W-1:0] setting1_q;
    logic bus_on_q;

    svdc_sync #(.WIDTH(RB_W)) u_rb_sync (
        .clk(SCL),
        .rst_n(RST_N),
        .async_in({bus_on_q, setting1_q, setting0_q}),
        .sync_out(rb_s)
    );

    wire [7:0] rd_lo = (cmd_q == CMD_SETTING0) ? {3'h0, rb_s[RB_S0_LSB +: CODE_W]} :
                       (cmd_q == CMD_SETTING1) ? {3'h0, rb_s[RB_S1_LSB +: CODE_W]} :
                       (cmd_q == CMD_ON_STATE) ? {7'h00, rb_s[RB_ON_BIT]} : BYTE_ZERO;
    wire [7:0] tx_byte = (ph_q == PH_RLO) ? rd_lo : BYTE_ZERO;
    wire [2:0] tx_idx = bit_q[2:0] ^ 3'h7;
    wire ack_drive = ack_slot && ((ph_q == PH_ADDR && addr_hit(sr_q)) ||
                     ph_q == PH_CMD || ph_q == PH_WLO || ph_q == PH_WHI);
    wire data_drive = !ack_slot && (ph_q == PH_RLO || ph_q == PH_RHI) && !tx_byte[tx_idx];

    always_ff @(negedge SCL or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            sda_oe_q <= 1'b0;
        end
        else
        begin
            sda_oe_q <= ack_drive | data_drive;
        end
    end

    assign SDA_OE = sda_oe_q;
    assign SDA_O = 1'b0;

    // ------------------------------------------------------------
    // write hand-over and commit at stop
    // ------------------------------------------------------------
    logic wr_tog_s;
    logic wr_tog_p_q;
    logic pend_q;
    logic pend_d;
    logic [7:0] pend_cmd_q;
    logic [CODE_W-1:0] pend_val_q;

    svdc_sync #(.WIDTH(1)) u_wr_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .async_in(wr_tog_q),
        .sync_out(wr_tog_s)
    );

    // cmd_q and lo_q stay still for microseconds after the toggle flips
    wire wr_evt = wr_tog_s ^ wr_tog_p_q;
    assign pend_d = wr_evt ? 1'b1 : ((start_det | stop_det) ? 1'b0 : pend_q);
    wire commit = stop_det & pend_q;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_tog_p_q <= 1'b0;
            pend_q <= 1'b0;
            pend_cmd_q <= BYTE_ZERO;
            pend_val_q <= CODE_RESET;
        end
        else
        begin
            wr_tog_p_q <= wr_tog_s;
            pend_q <= pend_d;
            pend_cmd_q <= wr_evt ? cmd_q : pend_cmd_q;
            pend_val_q <= wr_evt ? lo_q[CODE_W-1:0] : pend_val_q;
        end
    end

    // ------------------------------------------------------------
    // stored codes, on state and output control
    // ------------------------------------------------------------
    logic [CODE_W-1:0] vid_q;
    logic on_ok_q;
    logic [CONV_N-1:0] conv_oe_q;
    logic pok_oe_q;
    logic tmr_busy;

    wire [CODE_W-1:0] setting0_d = (commit && pend_cmd_q == CMD_SETTING0) ? pend_val_q : setting0_q;
    wire [CODE_W-1:0] setting1_d = (commit && pend_cmd_q == CMD_SETTING1) ? pend_val_q : setting1_q;
    wire bus_on_d = (commit && pend_cmd_q == CMD_ON_STATE) ? pend_val_q[0] : bus_on_q;
    wire [CODE_W-1:0] sel_code = sel_s ? setting1_q : setting0_q;
    wire on_ok = bus_on_q & global_supply_control_s;
    wire code_chg = (sel_code != vid_q);
    wire pg_start = code_chg | (on_ok & ~on_ok_q);

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            setting0_q <= CODE_RESET;
            setting1_q <= CODE_RESET;
            bus_on_q <= BUS_ON_RESET;
            vid_q <= CODE_RESET;
            on_ok_q <= 1'b0;
            conv_oe_q <= CONV_ALL_LOW;
            pok_oe_q <= 1'b1;
        end
        else
        begin
            setting0_q <= setting0_d;
            setting1_q <= setting1_d;
            bus_on_q <= bus_on_d;
            vid_q <= sel_code;
            on_ok_q <= on_ok;
            conv_oe_q <= {CONV_N{~on_ok}};
            pok_oe_q <= ~on_ok | tmr_busy;
        end
    end

    svdc_timer #(.CYCLES(PGL_LEN)) u_pgl_timer (
        .clk(CLOCK),
        .rst_n(RST_N),
        .start(pg_start),
        .busy(tmr_busy)
    );

    assign VOLTAGE_ID_CODE = vid_q;
    assign CONV_RUN_OE = conv_oe_q;
    assign CONV_RUN_O = '0;
    assign POWER_OK_OUT_OE = pok_oe_q;
    assign POWER_OK_OUT_O = 1'b0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] run_q;

    // counts the cycles of one uninterrupted timer run
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            run_q <= '0;
        end
        else
        begin
            run_q <= pg_start ? '0 : (tmr_busy ? run_q + 16'h0001 : run_q);
        end
    end

    sel_first_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !sel_s |=> VOLTAGE_ID_CODE == $past(setting0_q))
        else $error("select low did not give first code");

    sel_second_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        sel_s |=> VOLTAGE_ID_CODE == $past(setting1_q))
        else $error("select high did not give second code");

    conv_force_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !global_supply_control_s |=> CONV_RUN_OE == CONV_ALL_LOW)
        else $error("run outputs not pulled low with global control low");

    conv_release_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        bus_on_q && global_supply_control_s |=> CONV_RUN_OE == CONV_ALL_FREE)
        else $error("run outputs not released while enabled");

    pok_force_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !global_supply_control_s |=> POWER_OK_OUT_OE)
        else $error("power-good not low with global control low");

    pulse_begin_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        code_chg |=> ##1 POWER_OK_OUT_OE)
        else $error("code change did not pull power-good low");

    pulse_len_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $fell(tmr_busy) |-> run_q == 16'(PGL_LEN))
        else $error("power-good low pulse has wrong length");

    commit_stop_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !stop_det |=> $stable(bus_on_q) && $stable(setting0_q))
        else $error("stored state changed outside a stop");

    write_ack_a: assert property (@(posedge SCL) disable iff (!link_rst_n)
        ack_slot && (ph_q == PH_CMD || ph_q == PH_WLO) |-> SDA_OE)
        else $error("write byte not acknowledged");

    read_shift_a: assert property (@(posedge SCL) disable iff (!link_rst_n)
        ph_q == PH_RLO && !ack_slot |-> SDA_OE == !tx_byte[tx_idx])
        else $error("read bit not presented before rising edge");

endmodule // svdc_top

`default_nettype wire

// file: verification/svdc_host_model.sv
// behavioural smbus host driving the link of the vid divider control block
`timescale 1ns/1ps
`default_nettype none

module svdc_host_model #(
    parameter int QTR_NS = 250
) (
    // link pins; sda open drain on the host side, scl driven directly
    output logic scl,
    output logic sda_pull,
    input wire logic sda_in
);
    // ----------------------------------------------------------------
    // bit level; scl rests high between frames, sda released when idle
    // ----------------------------------------------------------------
    int stretch;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
        stretch = 0;
    end
    // data moves only while scl is low, so no false start or stop appears
    task automatic bit1(input logic b, output logic s);
        scl = 1'b0;
        #(QTR_NS);
        sda_pull = ~b;
        #(QTR_NS + stretch);
        scl = 1'b1;
        #(QTR_NS);
        s = sda_in;
        #(QTR_NS);
    endtask
    task automatic start_c;
        scl = 1'b0;
        #(QTR_NS);
        sda_pull = 1'b0;
        #(QTR_NS);
        scl = 1'b1;
        #(2 * QTR_NS);
        sda_pull = 1'b1;
        #(2 * QTR_NS);
    endtask
    task automatic stop_c;
        scl = 1'b0;
        #(QTR_NS);
        sda_pull = 1'b1;
        #(QTR_NS);
        scl = 1'b1;
        #(2 * QTR_NS);
        sda_pull = 1'b0;
        #(QTR_NS);
    endtask
    // nine clocks: eight data bits msb first, then the acknowledge slot
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--)
            bit1(o[k], i[k]);
    endtask
    // ----------------------------------------------------------------
    // word protocols; nbytes below four stops the write early
    // ----------------------------------------------------------------
    task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [7:0] lo,
                              input int nbytes, output logic [3:0] nacks);
        logic [8:0] r;
        logic [7:0] b [4];
        b = '{{a, 1'b0}, c, lo, 8'h00};
        nacks = 4'h0;
        start_c;
        for (int k = 0; k < nbytes; k++)
        begin
            xfer({b[k], 1'b1}, r);
            nacks[k] = r[0];
        end
        stop_c;
    endtask
    task automatic read_word(input logic [6:0] a, input logic [7:0] c, output logic [15:0] w);
        logic [8:0] r;
        start_c;
        xfer({a, 1'b0, 1'b1}, r);
        xfer({c, 1'b1}, r);
        start_c;
        xfer({a, 1'b1, 1'b1}, r);
        xfer(9'h1fe, r);
        w[7:0] = r[8:1];
        xfer(9'h1ff, r);
        w[15:8] = r[8:1];
        stop_c;
    endtask
endmodule // svdc_host_model

`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the smbus vid divider control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import svdc_pkg::*;
    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    localparam int PGL = 60;
    logic clock, rst_n, select, gsc, scl, sda_pull, sda_o, sda_oe, pg_o, pg_oe;
    logic [4:0] code, s0, s1;
    logic [2:0] run_o, run_oe;
    logic [3:0] acks;
    logic [15:0] rd_w, g, e;
    logic [31:0] rnd;
    int seed, err_count, n_checks, cyc, k;
    int kind_q[$];
    logic [15:0] exp_q[$];
    event got_ev;
    wire sda_wire = ~(sda_pull | sda_oe);

    svdc_top #(.PGL_LEN(PGL)) DUT (.CLOCK(clock), .RST_N(rst_n), .SCL(scl), .SDA_I(sda_wire),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .SELECT(select), .GLOBAL_SUPPLY_CONTROL(gsc),
        .VOLTAGE_ID_CODE(code), .CONV_RUN_O(run_o), .CONV_RUN_OE(run_oe),
        .POWER_OK_OUT_O(pg_o), .POWER_OK_OUT_OE(pg_oe));
    // the host runs slower than the link clock asked for: the slave needs long scl lows
    svdc_host_model host (.scl(scl), .sda_pull(sda_pull), .sda_in(sda_wire));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // expectation queue and output monitor
    // ----------------------------------------------------------------
    task automatic note(input int kd, input logic [15:0] ev);
        kind_q.push_back(kd);
        exp_q.push_back(ev);
        -> got_ev;
    endtask
    initial
    forever
    begin
        @(got_ev);
        while (exp_q.size() > 0)
        begin
            k = kind_q.pop_front();
            e = exp_q.pop_front();
            case (k)
                0: g = rd_w;
                1: g = {11'h0, code};
                2: g = {13'h0, run_oe};
                3: g = {15'h0, pg_oe};
                5: g = {11'h0, pg_o, run_o, sda_o};
                default: g = {12'h0, acks};
            endcase
            n_checks++;
            if (g !== e)
            begin
                err_count++;
                $display("wrong value at %0t: kind %0d got %h expected %h", $time, k, g, e);
            end
        end
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            give_verdict;
        end
    end
    // ----------------------------------------------------------------
    // bus tasks and pulse check
    // ----------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] lo, input int n,
                      input logic [3:0] ea);
        host.write_word(a, c, lo, n, acks);
        note(4, {12'h0, ea});
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] ev);
        host.read_word(DEV_ADDR_DEFAULT, c, rd_w);
        note(0, ev);
    endtask
    // pulse must still be low PGL - 15 cycles on, then be released 25 cycles after that
    task automatic pulse_chk;
        note(3, 16'h0001);
        repeat (PGL - 15) @(negedge clock);
        note(3, 16'h0001);
        repeat (25) @(negedge clock);
        note(3, 16'h0000);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 32'h1f1f;
        err_count = 0;
        n_checks = 0;
        cyc = 0;
        select = 1'b0;
        gsc = 1'b1;
        rst_n = 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        repeat (6) @(negedge clock);
        note(1, 16'h001f);
        note(2, 16'(CONV_ALL_LOW));
        note(3, 16'h0001);
        note(5, 16'h0000);
        for (int c = 0; c < 4; c++)
            rd(8'(c), (c < 2) ? 16'h001f : 16'h0000);
        rnd = $random(seed);
        s0 = rnd[4:0];
        s1 = s0 ^ 5'h0a;
        wr(DEV_ADDR_DEFAULT, CMD_SETTING0, {3'h0, s0}, 4, 4'h0);
        wr(DEV_ADDR_DEFAULT, CMD_SETTING1, {3'h0, s1}, 4, 4'h0);
        rd(CMD_SETTING0, {11'h0, s0});
        rd(CMD_SETTING1, {11'h0, s1});
        repeat (8) @(negedge clock);
        note(1, {11'h0, s0});
        select = 1'b1;
        repeat (8) @(negedge clock);
        note(1, {11'h0, s1});
        wr(DEV_ADDR_DEFAULT, CMD_ON_STATE, 8'h01, 4, 4'h0);
        note(2, 16'(CONV_ALL_FREE));
        pulse_chk;
        rd(CMD_ON_STATE, 16'h0001);
        select = 1'b0;
        repeat (10) @(negedge clock);
        pulse_chk;
        note(1, {11'h0, s0});
        gsc = 1'b0;
        repeat (8) @(negedge clock);
        note(2, 16'(CONV_ALL_LOW));
        note(3, 16'h0001);
        gsc = 1'b1;
        repeat (10) @(negedge clock);
        note(2, 16'(CONV_ALL_FREE));
        pulse_chk;
        // a write cut short before its high byte must leave the state alone
        wr(DEV_ADDR_DEFAULT, CMD_ON_STATE, 8'h00, 3, 4'h0);
        repeat (10) @(negedge clock);
        note(2, 16'(CONV_ALL_FREE));
        rd(CMD_ON_STATE, 16'h0001);
        wr(DEV_ADDR_DEFAULT ^ 7'h01, CMD_SETTING0, 8'h00, 4, 4'hf);
        rd(CMD_SETTING0, {11'h0, s0});
        host.stretch = 2000;
        wr(DEV_ADDR_DEFAULT, CMD_SETTING0, {3'h0, s0 ^ 5'h10}, 4, 4'h0);
        host.stretch = 0;
        repeat (2) @(negedge clock);
        pulse_chk;
        note(1, {11'h0, s0 ^ 5'h10});
        wr(DEV_ADDR_DEFAULT, CMD_ON_STATE, 8'h00, 4, 4'h0);
        repeat (4) @(negedge clock);
        note(2, 16'(CONV_ALL_LOW));
        note(3, 16'h0001);
        repeat (4) @(negedge clock);
        give_verdict;
    end
endmodule // tb_top

`default_nettype wire
